// File: verilog/seq_pkg.sv
// Constants, register map and types shared by the channel sequencer files
package seq_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES_DEF = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Sizes
   localparam int NUM_CH  = 4;
   localparam int NUM_GRP = 3;
   localparam int NUM_PIN = 5;
   localparam int ORD_W   = 2;
   localparam int DLY_W   = 8;
   localparam int RATE_W  = 16;
   localparam int SLOT_W  = 4;
   localparam logic [SLOT_W-1:0] SLOT_LAST = 4'hF;

   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CMD    = 8'h04;
   localparam logic [7:0] ADDR_PINSEL = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_MON    = 8'h10;
   localparam logic [7:0] ADDR_CHCFG  = 8'h20;
   localparam logic [7:0] ADDR_RAMP   = 8'h30;

   // ==========================================================
   // Field positions
   localparam int CTRL_STANDBY = 0;
   localparam int CTRL_AUTORST = 1;
   localparam int CMD_GUP_LSB  = 0;
   localparam int CMD_GDN_LSB  = 3;
   localparam int CMD_CUP_LSB  = 6;
   localparam int CMD_CDN_LSB  = 10;
   localparam int CFG_GRP_LSB  = 0;
   localparam int CFG_UORD_LSB = 2;
   localparam int CFG_DORD_LSB = 4;
   localparam int CFG_WPG      = 6;
   localparam int CFG_WSTOP    = 7;
   localparam int CFG_UDLY_LSB = 8;
   localparam int CFG_DDLY_LSB = 16;
   localparam int PSEL_G1_LSB  = 0;
   localparam int PSEL_G2_LSB  = 4;
   localparam int PSEL_W       = 3;
   localparam int PIN_OE_LSB   = 16;
   localparam int PIN_OUT_LSB  = 24;
   localparam int MON_TEMP_LSB = 8;
   localparam logic [1:0] GRP_NONE = 2'h3;

   // ==========================================================
   // Reset values and scaling
   localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] PINSEL_RST = 32'h0000_0077;
   localparam logic [31:0] CHCFG_RST  = 32'h0000_0000;
   localparam logic [15:0] RAMP_RST   = 16'h0000;
   localparam logic [15:0] VCC_STEP_MV = 16'h00C8;
   localparam logic [15:0] TEMP_STEP_C = 16'h0005;
   localparam logic [NUM_CH-1:0] CH_ALL      = 4'hF;
   localparam logic [NUM_CH-1:0] CH_INTERNAL = 4'hC;

   typedef enum logic [1:0] {
      S_IDLE  = 2'b00,
      S_SCAN  = 2'b01,
      S_DELAY = 2'b10,
      S_WAIT  = 2'b11
   } seq_state_t;

   function automatic logic [7:0] to_code(input logic [15:0] v,
                                          input logic [15:0] step);
      logic [15:0] q;
      q = v / step;
      return q[7:0];
   endfunction
endpackage

// File: verilog/ms_tick.sv
// Millisecond tick generator
`timescale 1ns/1ps
module ms_tick #(
   parameter int CYCLES = 200000
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic clear,
   output logic      tick
);
   logic [31:0] cnt;
   wire         wrap = (cnt == 32'(CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt  <= 32'h0000_0000;
         tick <= 1'b0;
      end else begin
         cnt  <= (wrap || clear) ? 32'h0000_0000 : cnt + 32'h0000_0001;
         tick <= wrap && !clear;
      end
   end
endmodule

// File: verilog/grp_seq.sv
// Ordered up/down walk over the member channels of one group
`timescale 1ns/1ps
module grp_seq import seq_pkg::*; (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    clear,
   input  wire logic                    tick,
   input  wire logic                    go_up,
   input  wire logic                    go_down,
   input  wire logic [NUM_CH-1:0]       member,
   input  wire logic [ORD_W*NUM_CH-1:0] up_ord,
   input  wire logic [ORD_W*NUM_CH-1:0] dn_ord,
   input  wire logic [NUM_CH-1:0]       wait_pg,
   input  wire logic [NUM_CH-1:0]       wait_stop,
   input  wire logic [DLY_W*NUM_CH-1:0] up_dly,
   input  wire logic [DLY_W*NUM_CH-1:0] dn_dly,
   input  wire logic [NUM_CH-1:0]       power_good_flag,
   input  wire logic [NUM_CH-1:0]       below_stop,
   output logic [NUM_CH-1:0]            on,
   output logic                         busy
);
   seq_state_t        state;
   seq_state_t        next_state;
   logic              up;
   logic [SLOT_W-1:0] slot;
   logic [DLY_W-1:0]  cnt;

   // Slot = {order position, channel}: every channel at one order value, then the next order value
   wire [1:0]       cur_ch  = slot[1:0];
   wire [ORD_W-1:0] cur_pos = slot[3:2];
   wire [ORD_W-1:0] cur_ord = up ? up_ord[cur_ch*ORD_W +: ORD_W]
                                 : dn_ord[cur_ch*ORD_W +: ORD_W];
   wire [DLY_W-1:0] cur_dly = up ? up_dly[cur_ch*DLY_W +: DLY_W]
                                 : dn_dly[cur_ch*DLY_W +: DLY_W];
   wire hit      = member[cur_ch] && (cur_ord == cur_pos);
   wire cur_wait = up ? wait_pg[cur_ch] : wait_stop[cur_ch];
   wire cond_met = up ? power_good_flag[cur_ch] : below_stop[cur_ch];
   wire go       = go_up || go_down;
   wire fire     = (state == S_DELAY) && (cnt == '0);
   wire advance  = ((state == S_SCAN) && !hit)
                || (fire && !cur_wait)
                || ((state == S_WAIT) && cond_met);

   always_comb begin
      next_state = state;
      unique case (state)
         S_IDLE:  next_state = S_IDLE;
         S_SCAN:  next_state = hit ? S_DELAY : S_SCAN;
         S_DELAY: if (fire) next_state = cur_wait ? S_WAIT : S_SCAN;
         S_WAIT:  if (cond_met) next_state = S_SCAN;
      endcase
      if (advance && slot == SLOT_LAST) next_state = S_IDLE;
      if (go) next_state = S_SCAN;
      if (clear) next_state = S_IDLE;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         up    <= 1'b0;
         slot  <= '0;
         cnt   <= '0;
         on    <= '0;
      end else begin
         state <= next_state;
         if (clear) begin
            on <= '0;
         end else if (go) begin
            up   <= go_up;
            slot <= '0;
         end else begin
            if (advance) slot <= slot + 4'h1;
            if (state == S_SCAN && hit) cnt <= cur_dly;
            else if (state == S_DELAY && tick && cnt != '0)
               cnt <= cnt - 8'h01;
            if (fire) on[cur_ch] <= up;
         end
      end
   end

   assign busy = (state != S_IDLE);
endmodule

// File: verilog/seq_top.sv
// Channel group power sequencer with APB register file
`timescale 1ns/1ps
// Behaviour
// - Group 0 starts when enabled and configured
// - Group 0 shuts down when enable falls
// - Host commands override pin edges, not enable
// - Groups 1, 2 follow assigned pin edges
// - Ungrouped channels are controlled individually
// - Each channel ramps at its own rate
// - Rise follows per-channel start-up order
// - Optional wait for power good
// - Start-up delay in ms, 0 to 255
// - Fall follows per-channel shut-down order
// - Optional wait for stop threshold
// - Shut-down delay in ms, 0 to 255
// - Supply readback in 200 mV steps
// - Temperature readback in 5 C steps
// - Auto-reset and reboot after store programming
// - Enable input has weak pull-up
// - Enable held low keeps device shut down
// - Standby: channels off, pins input, clock off
// - Internal-only variant uses channels 2, 3
module seq_top import seq_pkg::*; #(
   parameter int   MS_CYCLES     = MS_CYCLES_DEF,
   parameter logic INTERNAL_ONLY = 1'b0
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic [7:0]               paddr,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     enable_in,
   input  wire logic                     cfg_loaded,
   input  wire logic                     nvm_prog_done,
   input  wire logic [NUM_PIN-1:0]       ctl_pin_in,
   output logic      [NUM_PIN-1:0]       ctl_pin_out,
   output logic      [NUM_PIN-1:0]       ctl_pin_oe,
   input  wire logic [NUM_CH-1:0]        power_good_flag,
   input  wire logic [NUM_CH-1:0]        below_stop,
   input  wire logic [15:0]              vcc_mv,
   input  wire logic [15:0]              temp_c,
   output logic      [NUM_CH-1:0]        ch_run,
   output logic      [RATE_W*NUM_CH-1:0] ch_ramp_rate,
   output logic                          enable_pullup_en,
   output logic                          sys_clk_en,
   output logic                          shutdown,
   output logic                          boot_req
);
   // ==========================================================
   // Register file
   logic [31:0]       ctrl;
   logic [31:0]       pinsel;
   logic [31:0]       chcfg [NUM_CH];
   logic [RATE_W-1:0] ramp  [NUM_CH];

   wire acc    = psel && penable;
   wire wr     = acc && pwrite;
   wire is_cfg = (paddr[7:4] == ADDR_CHCFG[7:4]) && (paddr[1:0] == 2'b00);
   wire is_rmp = (paddr[7:4] == ADDR_RAMP[7:4]) && (paddr[1:0] == 2'b00);
   wire [1:0] reg_idx = paddr[3:2];
   wire hit_ctrl = (paddr == ADDR_CTRL);
   wire hit_cmd  = (paddr == ADDR_CMD);
   wire hit_psel = (paddr == ADDR_PINSEL);
   wire hit_stat = (paddr == ADDR_STATUS);
   wire hit_mon  = (paddr == ADDR_MON);
   wire mapped   = hit_ctrl || hit_cmd || hit_psel || hit_stat
                || hit_mon || is_cfg || is_rmp;

   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

   wire standby = ctrl[CTRL_STANDBY];
   wire autorst = ctrl[CTRL_AUTORST];

   // Host command pulses, one cycle wide, from a write to the command word
   wire cmd_wr = wr && hit_cmd;
   wire [NUM_GRP-1:0] host_gup =
      cmd_wr ? pwdata[CMD_GUP_LSB +: NUM_GRP] : '0;
   wire [NUM_GRP-1:0] host_gdn =
      cmd_wr ? pwdata[CMD_GDN_LSB +: NUM_GRP] : '0;
   wire [NUM_CH-1:0] host_cup =
      cmd_wr ? pwdata[CMD_CUP_LSB +: NUM_CH] : '0;
   wire [NUM_CH-1:0] host_cdn =
      cmd_wr ? pwdata[CMD_CDN_LSB +: NUM_CH] : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl   <= CTRL_RST;
         pinsel <= PINSEL_RST;
         for (int i = 0; i < NUM_CH; i++) begin
            chcfg[i] <= CHCFG_RST;
            ramp[i]  <= RAMP_RST;
         end
      end else if (wr) begin
         if (hit_ctrl) ctrl <= pwdata;
         if (hit_psel) pinsel <= pwdata;
         if (is_cfg) chcfg[reg_idx] <= pwdata;
         if (is_rmp) ramp[reg_idx] <= pwdata[RATE_W-1:0];
      end
   end

   // ==========================================================
   // Channel configuration fields
   logic [NUM_CH-1:0]       mem_g [NUM_GRP];
   logic [NUM_CH-1:0]       solo;
   logic [ORD_W*NUM_CH-1:0] up_ord;
   logic [ORD_W*NUM_CH-1:0] dn_ord;
   logic [NUM_CH-1:0]       wait_pg;
   logic [NUM_CH-1:0]       wait_stop;
   logic [DLY_W*NUM_CH-1:0] up_dly;
   logic [DLY_W*NUM_CH-1:0] dn_dly;

   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         for (int g = 0; g < NUM_GRP; g++)
            mem_g[g][i] = (chcfg[i][CFG_GRP_LSB +: 2] == 2'(g));
         solo[i] = (chcfg[i][CFG_GRP_LSB +: 2] == GRP_NONE);
         up_ord[i*ORD_W +: ORD_W] = chcfg[i][CFG_UORD_LSB +: ORD_W];
         dn_ord[i*ORD_W +: ORD_W] = chcfg[i][CFG_DORD_LSB +: ORD_W];
         wait_pg[i]   = chcfg[i][CFG_WPG];
         wait_stop[i] = chcfg[i][CFG_WSTOP];
         up_dly[i*DLY_W +: DLY_W] = chcfg[i][CFG_UDLY_LSB +: DLY_W];
         dn_dly[i*DLY_W +: DLY_W] = chcfg[i][CFG_DDLY_LSB +: DLY_W];
         ch_ramp_rate[i*RATE_W +: RATE_W] = ramp[i];
      end
   end

   // ==========================================================
   // Group triggers
   logic               en_ok_q;
   logic [2:1]         pin_q;
   logic [NUM_CH-1:0]  solo_on;
   logic               clear;

   wire en_ok = enable_in && cfg_loaded;
   wire [PSEL_W-1:0] sel1 = pinsel[PSEL_G1_LSB +: PSEL_W];
   wire [PSEL_W-1:0] sel2 = pinsel[PSEL_G2_LSB +: PSEL_W];
   // Out-of-range selection means no pin controls the group
   wire pin1 = (sel1 < PSEL_W'(NUM_PIN)) ? ctl_pin_in[sel1] : 1'b0;
   wire pin2 = (sel2 < PSEL_W'(NUM_PIN)) ? ctl_pin_in[sel2] : 1'b0;

   wire [NUM_GRP-1:0] pin_up;
   wire [NUM_GRP-1:0] pin_dn;
   assign pin_up[0] = en_ok && !en_ok_q;
   assign pin_dn[0] = !en_ok && en_ok_q;
   assign pin_up[1] = pin1 && !pin_q[1];
   assign pin_dn[1] = !pin1 && pin_q[1];
   assign pin_up[2] = pin2 && !pin_q[2];
   assign pin_dn[2] = !pin2 && pin_q[2];

   // A host command to a group masks any pin edge in the same cycle
   wire [NUM_GRP-1:0] host_any = host_gup | host_gdn;
   wire [NUM_GRP-1:0] go_up = host_gup | (pin_up & ~host_any);
   wire [NUM_GRP-1:0] go_dn = (host_gdn & ~host_gup)
                            | (pin_dn & ~host_any);

   // Reboot drops every sequence and re-arms the enable edge
   assign clear = nvm_prog_done && autorst;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_ok_q  <= 1'b0;
         pin_q    <= '0;
         solo_on  <= '0;
         boot_req <= 1'b0;
      end else begin
         en_ok_q  <= clear ? 1'b0 : en_ok;
         // Pin history holds in standby, so a pin edge then keeps re-triggering its group until standby ends
         pin_q    <= standby ? pin_q : {pin2, pin1};
         boot_req <= clear;
         if (clear || shutdown)
            solo_on <= '0;
         else
            solo_on <= (solo_on | (host_cup & solo)) & ~host_cdn;
      end
   end

   // ==========================================================
   // Group walkers
   wire               tick;
   wire [NUM_CH-1:0]  grp_on [NUM_GRP];
   wire [NUM_GRP-1:0] grp_busy;

   ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (clear),
      .tick    (tick)
   );

   for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
      grp_seq u_seq (
         .pclk            (pclk),
         .presetn         (presetn),
         .clear           (clear),
         .tick            (tick),
         .go_up           (go_up[g]),
         .go_down         (go_dn[g]),
         .member          (mem_g[g]),
         .up_ord          (up_ord),
         .dn_ord          (dn_ord),
         .wait_pg         (wait_pg),
         .wait_stop       (wait_stop),
         .up_dly          (up_dly),
         .dn_dly          (dn_dly),
         .power_good_flag (power_good_flag),
         .below_stop      (below_stop),
         .on              (grp_on[g]),
         .busy            (grp_busy[g])
      );
   end

   // ==========================================================
   // Channel outputs and pins
   // Each channel sits in one group only, so an OR of masked walkers
   wire [NUM_CH-1:0] avail = INTERNAL_ONLY ? CH_INTERNAL : CH_ALL;
   wire [NUM_CH-1:0] want  = (grp_on[0] & mem_g[0])
                           | (grp_on[1] & mem_g[1])
                           | (grp_on[2] & mem_g[2])
                           | (solo_on & solo);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch_run      <= '0;
         ctl_pin_oe  <= '0;
         ctl_pin_out <= '0;
         shutdown    <= 1'b1;
         sys_clk_en  <= 1'b0;
      end else begin
         shutdown    <= !enable_in;
         sys_clk_en  <= !standby;
         ch_run      <= (standby || shutdown) ? '0 : (want & avail);
         ctl_pin_oe  <= standby ? '0 : pinsel[PIN_OE_LSB +: NUM_PIN];
         ctl_pin_out <= pinsel[PIN_OUT_LSB +: NUM_PIN];
      end
   end

   // Pull-up request stays on so a floating enable still starts the part
   assign enable_pullup_en = 1'b1;

   // ==========================================================
   // Read data
   wire [7:0] vcc_code  = to_code(vcc_mv, VCC_STEP_MV);
   wire [7:0] temp_code = to_code(temp_c, TEMP_STEP_C);
   wire [31:0] status = {17'h0, standby, shutdown, grp_busy,
                         power_good_flag, 2'h0, ch_run};
   wire [31:0] mon = {16'h0, temp_code, vcc_code} & 32'h0000_FFFF;

   logic [31:0] next_prdata;
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (hit_ctrl) next_prdata = ctrl;
      if (hit_psel) next_prdata = pinsel;
      if (hit_stat) next_prdata = status;
      if (hit_mon)  next_prdata = mon;
      if (is_cfg)   next_prdata = chcfg[reg_idx];
      if (is_rmp)   next_prdata = {16'h0, ramp[reg_idx]};
   end

   // Read data is latched in the setup cycle, valid in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite) prdata <= next_prdata;
   end
endmodule

// File: tb/plant_model.sv
// Behavioural power stage model answering the run requests
`timescale 1ns/1ps
module plant_model import seq_pkg::*; #(
   parameter int LAT = 20
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [NUM_CH-1:0] ch_run,
   output logic      [NUM_CH-1:0] power_good_flag,
   output logic      [NUM_CH-1:0] below_stop
);
   int                cnt [NUM_CH];
   logic [NUM_CH-1:0] last;
   // ==========================================================
   // Ramp time stand-in: LAT cycles after each change
   always @(posedge pclk or negedge presetn)
      for (int i = 0; i < NUM_CH; i++)
         if (!presetn) cnt[i] <= LAT;
         else if (ch_run[i] !== last[i]) cnt[i] <= 0;
         else if (cnt[i] < LAT) cnt[i] <= cnt[i] + 1;
   always @(posedge pclk or negedge presetn)
      last <= presetn ? ch_run : '0;
   always_comb
      for (int i = 0; i < NUM_CH; i++) begin
         power_good_flag[i] = last[i] && cnt[i] == LAT;
         below_stop[i] = !last[i] && cnt[i] == LAT;
      end
endmodule

// File: tb/seq_checker.sv
// Port-level assertions for the channel sequencer
`timescale 1ns/1ps
module seq_checker import seq_pkg::*; (
   input wire logic                     pclk,
   input wire logic                     presetn,
   input wire logic [7:0]               paddr,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [31:0]              prdata,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire logic                     enable_in,
   input wire logic                     nvm_prog_done,
   input wire logic [NUM_PIN-1:0]       ctl_pin_oe,
   input wire logic [NUM_CH-1:0]        ch_run,
   input wire logic [RATE_W*NUM_CH-1:0] ch_ramp_rate,
   input wire logic [15:0]              vcc_mv,
   input wire logic [15:0]              temp_c,
   input wire logic                     enable_pullup_en,
   input wire logic                     sys_clk_en,
   input wire logic                     shutdown,
   input wire logic                     boot_req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic acc = psel && penable;
   wire logic mapped = (paddr inside {ADDR_CTRL, ADDR_CMD, ADDR_PINSEL,
      ADDR_STATUS, ADDR_MON}) ||
      (paddr[1:0] == 2'h0 && paddr[7:4] inside {4'h2, 4'h3});
   // ==========================================================
   // Bus
   property p_rdy;
      acc |-> pready;
   endproperty
   a_rdy: assert property (p_rdy) else $error("pready low");
   property p_err;
      acc |-> pslverr == !mapped;
   endproperty
   a_err: assert property (p_err) else $error("pslverr wrong");
   property p_mon;
      psel && !penable && !pwrite && paddr == ADDR_MON |=> prdata ==
         {16'h0000, 8'($past(temp_c) / TEMP_STEP_C),
          8'($past(vcc_mv) / VCC_STEP_MV)};
   endproperty
   a_mon: assert property (p_mon) else $error("monitor code");
   property p_ramp;
      !(acc && pwrite && paddr[7:4] == 4'h3) |=> $stable(ch_ramp_rate);
   endproperty
   a_ramp: assert property (p_ramp) else $error("rate moved");
   // ==========================================================
   // Power control
   property p_shut;
      $past(presetn) |-> shutdown == !$past(enable_in);
   endproperty
   a_shut: assert property (p_shut) else $error("shutdown lag");
   property p_enoff;
      !enable_in [*4] |-> ch_run == 4'h0;
   endproperty
   a_enoff: assert property (p_enoff) else $error("run while off");
   property p_stby;
      !sys_clk_en && $past(!sys_clk_en) |-> ctl_pin_oe == 5'h00 &&
         ch_run == 4'h0;
   endproperty
   a_stby: assert property (p_stby) else $error("standby leak");
   property p_pull;
      enable_pullup_en;
   endproperty
   a_pull: assert property (p_pull) else $error("no pull-up");
   property p_boot;
      boot_req |-> ($past(nvm_prog_done) || $past(nvm_prog_done, 2))
         ##1 !boot_req;
   endproperty
   a_boot: assert property (p_boot) else $error("boot pulse");
   c_all: cover property (ch_run == 4'hF);
   c_boot: cover property (boot_req);
   c_err: cover property (acc && pslverr);
   c_stby: cover property (!sys_clk_en);
endmodule
bind seq_top seq_checker chk_i (.*);

// File: tb/channel_group_power_sequencer_tb.sv
// Self-checking bench for the channel group sequencer
`timescale 1ns/1ps
module channel_group_power_sequencer_tb import seq_pkg::*;;
   localparam int MS = 10;
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, er;
   logic        enable_in = 1'b0, cfg_loaded = 1'b0, nvm_prog_done = 1'b0;
   logic [4:0]  ctl_pin_in = 5'h00, ctl_pin_out, ctl_pin_oe;
   logic [3:0]  power_good_flag, below_stop, ch_run, ch_run_int;
   logic [15:0] vcc_mv = 16'h2F44, temp_c = 16'h002F;
   logic [63:0] ch_ramp_rate;
   logic        enable_pullup_en, sys_clk_en, shutdown, boot_req;
   int          n_errors = 0, checks = 0;
   int          tm [4];
   always #2.5 pclk = !pclk;
   seq_top #(.MS_CYCLES(MS), .INTERNAL_ONLY(1'b0)) dut (.pclk, .presetn,
      .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .enable_in, .cfg_loaded, .nvm_prog_done, .ctl_pin_in,
      .ctl_pin_out, .ctl_pin_oe, .power_good_flag, .below_stop, .vcc_mv,
      .temp_c, .ch_run, .ch_ramp_rate, .enable_pullup_en, .sys_clk_en,
      .shutdown, .boot_req);
   plant_model #(.LAT(20)) plant (.pclk, .presetn, .ch_run,
      .power_good_flag, .below_stop);
   // Internal-stage variant sees the same inputs, only its runs differ
   seq_top #(.MS_CYCLES(MS), .INTERNAL_ONLY(1'b1)) dut_int (.pclk,
      .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata(),
      .pready(), .pslverr(), .enable_in, .cfg_loaded, .nvm_prog_done,
      .ctl_pin_in, .ctl_pin_out(), .ctl_pin_oe(), .power_good_flag,
      .below_stop, .vcc_mv, .temp_c, .ch_run(ch_run_int),
      .ch_ramp_rate(), .enable_pullup_en(), .sys_clk_en(), .shutdown(),
      .boot_req());
   // ==========================================================
   // Shared tasks
   task automatic wrap_up;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (n = 0; pready !== 1'b1 && n < 50; n++)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50) chk("pready", 32'h1, 32'h0);
      if (n == 50) wrap_up;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   // Records the cycle at which each run bit first changes
   task automatic run_to(input logic [3:0] goal);
      int n;
      logic [3:0] prev;
      @(negedge pclk);
      prev = ch_run;
      for (int i = 0; i < 4; i++) tm[i] = -1;
      for (n = 0; n < 3000 && ch_run !== goal; n++) begin
         @(negedge pclk);
         for (int i = 0; i < 4; i++)
            if (tm[i] < 0 && ch_run[i] !== prev[i]) tm[i] = n;
      end
      chk("ch_run", 32'(goal), 32'(ch_run));
      if (n == 3000) wrap_up;
   endtask
   task automatic pin(input logic [4:0] v, input logic [3:0] goal);
      @(posedge pclk);
      ctl_pin_in <= v;
      run_to(goal);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs;
      rdc(ADDR_PINSEL, PINSEL_RST, "pinsel");
      rdc(ADDR_CTRL, CTRL_RST, "ctrl");
      rdc(ADDR_CHCFG, CHCFG_RST, "chcfg");
      rdc(ADDR_CMD, 32'h0, "cmd");
      wr(8'h14, 32'hFFFF_FFFF);
      chk("wr err", 32'h1, 32'(er));
      rdc(8'h14, 32'h0, "unmapped");
      chk("rd err", 32'h1, 32'(er));
      wr(8'h34, 32'h0000_1234);
      rdc(8'h34, 32'h0000_1234, "ramp");
      chk("rate", 32'h1234, 32'(ch_ramp_rate[31:16]));
      rdc(ADDR_MON, 32'h0000_093C, "mon");
   endtask
   task automatic t_up;
      wr(ADDR_CHCFG, 32'h0000_0108);
      wr(8'h24, 32'h0002_00D0);
      wr(8'h28, 32'h0000_0324);
      wr(8'h2C, 32'h0000_003C);
      @(posedge pclk);
      cfg_loaded <= 1'b1;
      run_to(4'hF);
      chk("internal", 32'h0C, 32'(ch_run_int));
      chk("up order", 32'h1,
          32'(tm[1] < tm[2] && tm[2] < tm[0] && tm[0] < tm[3]));
      chk("pg wait", 32'h1, 32'(tm[2] - tm[1] > 20 + 2 * MS));
   endtask
   task automatic t_down;
      wr(ADDR_CMD, 32'h0000_0008);
      run_to(4'h0);
      chk("dn order", 32'h1,
          32'(tm[0] < tm[1] && tm[1] < tm[2] && tm[2] < tm[3]));
      chk("dn delay", 32'h1, 32'(tm[1] - tm[0] > MS));
      chk("stop wait", 32'h1, 32'(tm[2] - tm[1] > 20));
   endtask
   task automatic t_pins;
      wr(8'h28, 32'h0000_0001);
      wr(8'h2C, 32'h0000_0002);
      wr(ADDR_PINSEL, 32'h0A0B_0042);
      repeat (2) @(negedge pclk);
      chk("oe", 32'h0B, 32'(ctl_pin_oe));
      chk("out", 32'h0A, 32'(ctl_pin_out));
      pin(5'h04, 4'h4);
      pin(5'h14, 4'hC);
      pin(5'h10, 4'h8);
      pin(5'h00, 4'h0);
   endtask
   task automatic t_solo;
      wr(ADDR_CHCFG, 32'h0000_0003);
      wr(ADDR_CMD, 32'h0000_0040);
      run_to(4'h1);
      pin(5'h04, 4'h5);
      wr(ADDR_CMD, 32'h0000_0400);
      run_to(4'h4);
      pin(5'h00, 4'h0);
   endtask
   task automatic t_enable;
      wr(ADDR_CMD, 32'h0000_0001);
      run_to(4'h2);
      @(posedge pclk);
      enable_in <= 1'b0;
      run_to(4'h0);
      chk("shutdown", 32'h1, 32'(shutdown));
      wr(ADDR_CMD, 32'h0000_0001);
      repeat (20) @(negedge pclk);
      chk("held off", 32'h0, 32'(ch_run));
      @(posedge pclk);
      enable_in <= 1'b1;
      run_to(4'h2);
   endtask
   task automatic t_standby;
      wr(ADDR_CTRL, 32'h0000_0001);
      run_to(4'h0);
      chk("clk en", 32'h0, 32'(sys_clk_en));
      chk("oe off", 32'h0, 32'(ctl_pin_oe));
      rdc(ADDR_STATUS, 32'h0000_4400, "status");
      wr(ADDR_CTRL, 32'h0000_0000);
      repeat (2) @(negedge pclk);
      chk("clk back", 32'h1, 32'(sys_clk_en));
   endtask
   task automatic t_boot;
      int n;
      wr(ADDR_CTRL, 32'h0000_0002);
      @(posedge pclk);
      nvm_prog_done <= 1'b1;
      @(posedge pclk);
      nvm_prog_done <= 1'b0;
      for (n = 0; n < 4 && boot_req !== 1'b1; n++)
         @(negedge pclk);
      chk("boot", 32'h1, 32'(boot_req));
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      enable_in <= 1'b1;
      t_regs;
      t_up;
      t_down;
      t_pins;
      t_solo;
      t_enable;
      t_standby;
      t_boot;
      wrap_up;
   end
endmodule
